// ==== rtl/fbd_defines.svh ====
// Constants for the flash bus host controller.
// Assumes inclusion by bare name from rtl files.
`ifndef FBD_DEFINES_SVH
`define FBD_DEFINES_SVH
`define FBD_ADDR_W 18
`define FBD_DATA_W 16
`define FBD_A6_BIT 6
`define FBD_A1_BIT 1
`define FBD_A0_BIT 0
`define FBD_SETUP_CYC 2
`define FBD_STROBE_CYC 4
`define FBD_HOLD_CYC 2
`define FBD_RST_CYC 25
`define FBD_CNT_W 8
`define FBD_BYTE_HI 15
`define FBD_OP_READ 2'h0
`define FBD_OP_WRITE 2'h1
`define FBD_OP_PROT 2'h2
`define FBD_OP_UNPROT 2'h3
`endif

// ==== rtl/fbd_pkg.sv ====
// Types for the flash bus host controller.
// Assumes fbd_defines.svh is on the include path.
`include "fbd_defines.svh"
package fbd_pkg;
	typedef logic [1:0] fbd_op_t;
	typedef enum logic [2:0] {
		FBD_RESET = 3'h0,
		FBD_IDLE = 3'h1,
		FBD_SETUP = 3'h2,
		FBD_STROBE = 3'h3,
		FBD_HOLD = 3'h4
	} fbd_state_e;
endpackage : fbd_pkg

// ==== rtl/fbd_host.sv ====
// Host controller driving an asynchronous parallel flash through its pins.
// Assumes the flash sits on pins beside it and the bench resolves data from enables.
// Functional notes
// - A read holds chip select and output gate low, write strobe high, reset inactive.
// - A write holds chip select low, output gate high, write strobe low, reset inactive.
// - Protect is a write with high-voltage reset and A6 low, A1 high, A0 low.
// - Unprotect is a write with high-voltage reset and A6 high, A1 high, A0 low.
`timescale 1ns/1ps
`default_nettype none
`include "fbd_defines.svh"
module fbd_host #(
	parameter int ADDR_W = `FBD_ADDR_W,
	parameter int DATA_W = `FBD_DATA_W
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Request
	input wire logic i_req,
	input wire fbd_pkg::fbd_op_t i_op,
	input wire logic i_byte_mode,
	input wire logic [ADDR_W:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	output logic o_ready,
	output logic o_done,
	output logic [DATA_W-1:0] o_rdata,
	// Flash pins
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic o_reset_n,
	output logic o_hv_select,
	output logic o_word_sel,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_dq_out,
	output logic [DATA_W-1:0] o_dq_oe,
	input wire logic [DATA_W-1:0] i_dq_in,
	input wire logic i_ready_busy_n,
	output logic o_dev_ready
);
	import fbd_pkg::*;
	// Widths and counts the logic serves
	if (ADDR_W != `FBD_ADDR_W || DATA_W != `FBD_DATA_W) begin : g_bad_width
		$error("fbd_host: unsupported widths");
	end
	if (`FBD_RST_CYC > (1 << `FBD_CNT_W) || `FBD_SETUP_CYC < 1 || `FBD_STROBE_CYC < 1 || `FBD_HOLD_CYC < 1) begin : g_bad_count
		$error("fbd_host: timing counts do not fit the counter");
	end
	fbd_state_e state_ff, nxt_state;
	logic [`FBD_CNT_W-1:0] cnt_ff;
	fbd_op_t op_ff;
	logic byte_ff;
	logic [ADDR_W:0] addr_ff;
	logic [DATA_W-1:0] wdata_ff;
	logic [2:0] rb_sync_ff;
	logic rb_ff;
	logic is_read;
	logic cnt_zero;
	fbd_op_t nxt_op;
	logic nxt_byte;
	logic [ADDR_W:0] nxt_addr;
	logic [DATA_W-1:0] nxt_wdata;
	logic nxt_is_read;
	logic nxt_busy;
	logic take;
	// Request taken this edge
	assign take = o_ready && i_req;
	assign nxt_is_read = (nxt_op == `FBD_OP_READ);
	assign nxt_busy = (nxt_state != FBD_IDLE) && (nxt_state != FBD_RESET);
	assign is_read = (op_ff == `FBD_OP_READ);
	assign cnt_zero = (cnt_ff == '0);
	assign o_ready = (state_ff == FBD_IDLE);
	// Ready pin resynchronised
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rb_sync_ff <= 3'h0;
			rb_ff <= 1'b0;
		end else begin
			rb_sync_ff <= {rb_sync_ff[1:0], i_ready_busy_n};
			if (rb_sync_ff[2] == rb_sync_ff[1])
				rb_ff <= rb_sync_ff[2];
		end
	end
	assign o_dev_ready = rb_ff;
	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			FBD_RESET: if (cnt_zero) nxt_state = FBD_IDLE;
			FBD_IDLE: if (i_req) nxt_state = FBD_SETUP;
			FBD_SETUP: if (cnt_zero) nxt_state = FBD_STROBE;
			FBD_STROBE: if (cnt_zero) nxt_state = FBD_HOLD;
			FBD_HOLD: if (cnt_zero) nxt_state = FBD_IDLE;
			default: nxt_state = FBD_RESET;
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (i_reset)
			state_ff <= FBD_RESET;
		else
			state_ff <= nxt_state;
	end
	always_ff @(posedge i_clk) begin
		if (i_reset)
			cnt_ff <= `FBD_CNT_W'(`FBD_RST_CYC - 1);
		else if (state_ff != nxt_state) begin
			unique case (nxt_state)
				FBD_SETUP: cnt_ff <= `FBD_CNT_W'(`FBD_SETUP_CYC - 1);
				FBD_STROBE: cnt_ff <= `FBD_CNT_W'(`FBD_STROBE_CYC - 1);
				FBD_HOLD: cnt_ff <= `FBD_CNT_W'(`FBD_HOLD_CYC - 1);
				default: cnt_ff <= '0;
			endcase
		end else if (!cnt_zero)
			cnt_ff <= cnt_ff - 1'b1;
	end
	// Request capture
	always_comb begin
		nxt_op = op_ff;
		nxt_byte = byte_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		if (take) begin
			nxt_op = i_op;
			nxt_byte = i_byte_mode;
			nxt_addr = i_addr;
			nxt_wdata = i_wdata;
			if (i_op == `FBD_OP_PROT || i_op == `FBD_OP_UNPROT) begin
				// Sector address bits sit one place up in byte mode
				if (i_byte_mode) begin
					nxt_addr[`FBD_A6_BIT+1] = (i_op == `FBD_OP_UNPROT);
					nxt_addr[`FBD_A1_BIT+1] = 1'b1;
					nxt_addr[`FBD_A0_BIT+1] = 1'b0;
				end else begin
					nxt_addr[`FBD_A6_BIT] = (i_op == `FBD_OP_UNPROT);
					nxt_addr[`FBD_A1_BIT] = 1'b1;
					nxt_addr[`FBD_A0_BIT] = 1'b0;
				end
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			op_ff <= `FBD_OP_READ;
			byte_ff <= 1'b0;
			addr_ff <= '0;
			wdata_ff <= '0;
		end else begin
			op_ff <= nxt_op;
			byte_ff <= nxt_byte;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
		end
	end
	// Bus strobes
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_reset_n <= 1'b0;
			o_hv_select <= 1'b0;
		end else begin
			o_reset_n <= (nxt_state != FBD_RESET);
			o_hv_select <= nxt_busy
				&& (nxt_op == `FBD_OP_PROT || nxt_op == `FBD_OP_UNPROT);
			o_ce_n <= !nxt_busy;
			o_oe_n <= !(nxt_state == FBD_STROBE && nxt_is_read);
			o_we_n <= !(nxt_state == FBD_STROBE && !nxt_is_read);
		end
	end
	// Address, width and write data
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_word_sel <= 1'b1;
			o_addr <= '0;
			o_dq_out <= '0;
		end else begin
			o_word_sel <= !nxt_byte;
			o_addr <= nxt_byte ? nxt_addr[ADDR_W:1] : nxt_addr[ADDR_W-1:0];
			o_dq_out <= nxt_wdata;
			if (nxt_byte)
				o_dq_out[`FBD_BYTE_HI] <= nxt_addr[0];
		end
	end
	// Data pin enables
	always_ff @(posedge i_clk) begin
		if (i_reset)
			o_dq_oe <= '0;
		else if (!nxt_busy)
			o_dq_oe <= '0;
		else if (!nxt_is_read)
			o_dq_oe <= nxt_byte ? 16'h80FF : 16'hFFFF;
		else
			o_dq_oe <= nxt_byte ? 16'h8000 : 16'h0000;
	end
	// End of access
	always_ff @(posedge i_clk) begin
		if (i_reset)
			o_done <= 1'b0;
		else
			o_done <= (state_ff == FBD_HOLD) && cnt_zero;
	end
	// Read data capture at end of strobe
	always_ff @(posedge i_clk) begin
		if (i_reset)
			o_rdata <= '0;
		else if (state_ff == FBD_STROBE && cnt_zero && is_read && o_reset_n)
			o_rdata <= byte_ff ? {8'h00, i_dq_in[7:0]} : i_dq_in;
	end
endmodule : fbd_host
`default_nettype wire

// ==== dv/fbd_flash_model.sv ====
// Behavioural flash device for the host bench.
// Clockless; the bench resolves the shared data bus.
`timescale 1ns/1ps
`default_nettype none
module fbd_flash_model (
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_reset_n,
	input wire logic i_hv,
	input wire logic i_word,
	input wire logic [17:0] i_addr,
	input wire logic [15:0] i_dq,
	output logic [15:0] o_dq,
	output logic [15:0] o_dq_en
);
	logic [15:0] cmd_ff = 16'h0;
	wire logic [15:0] w = i_addr[15:0] ^ 16'h5A3C;
	wire logic on = !i_ce_n && !i_oe_n && i_we_n && i_reset_n && !i_hv;
	assign o_dq = i_word ? w : {8'h0, i_dq[15] ? w[15:8] : w[7:0]};
	assign o_dq_en = on ? {{8{i_word}}, 8'hFF} : 16'h0;
	always @(posedge i_we_n) if (!i_ce_n && i_oe_n && i_reset_n)
		cmd_ff <= i_hv ? {13'h0, i_addr[6], i_addr[1:0]} : i_word ? i_dq : {8'h0, i_dq[7:0]};
endmodule : fbd_flash_model
`default_nettype wire

// ==== dv/fbd_host_checker.sv ====
// Pin sequencing checks for the flash host.
// Bound into fbd_host; one clock.
`timescale 1ns/1ps
`default_nettype none
module fbd_host_checker (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic o_done,
	input wire logic o_ce_n,
	input wire logic o_oe_n,
	input wire logic o_we_n,
	input wire logic o_reset_n,
	input wire logic o_hv_select,
	input wire logic o_word_sel,
	input wire logic [15:0] o_dq_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	chk_no_overlap: assert property (o_oe_n || o_we_n) else $error("oe we low");
	chk_read_pins:
		assert property (!o_oe_n |-> !o_ce_n && o_we_n && o_reset_n && o_dq_oe[14:0] == 15'h0000)
			else $error("rd");
	chk_word_read:
		assert property (!o_oe_n && o_word_sel |-> o_dq_oe == 16'h0000) else $error("word rd");
	chk_byte_float:
		assert property (!o_word_sel |-> o_dq_oe[14:8] == 7'h00) else $error("byte hi");
	chk_write_pins:
		assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_reset_n && o_dq_oe) else $error("wr");
	chk_reset_quiet: assert property (!o_reset_n |-> o_ce_n && !o_dq_oe) else $error("rst");
	chk_access_len:
		assert property ($fell(o_ce_n) |-> !o_ce_n [*8] ##1 o_done && o_ce_n) else $error("len");
	chk_strobe_len:
		assert property ($fell(o_we_n) |-> !o_we_n [*4] ##1 o_we_n) else $error("we");
	chk_read_len:
		assert property ($fell(o_oe_n) |-> !o_oe_n [*4] ##1 o_oe_n) else $error("oe");
	chk_hv_write:
		assert property (o_hv_select |-> !o_ce_n && o_oe_n) else $error("hv");
endmodule : fbd_host_checker
bind fbd_host fbd_host_checker u_fbd_host_checker (.i_clk(i_clk), .i_reset(i_reset),
	.o_done(o_done), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_reset_n(o_reset_n),
	.o_hv_select(o_hv_select), .o_word_sel(o_word_sel), .o_dq_oe(o_dq_oe));
`default_nettype wire

// ==== dv/test_flash_bus_operation_decode.sv ====
// Bench: host against a behavioural flash.
// Requests at falling edges; results checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module test_flash_bus_operation_decode;
	import fbd_pkg::*;
	logic i_clk = 1'b0, i_reset = 1'b1, i_req = 1'b0, i_byte_mode = 1'b0;
	fbd_op_t i_op = '0;
	logic [18:0] i_addr = '0;
	logic [15:0] i_wdata = '0, idle = 16'h55AA, s, w;
	logic [16:0] e, q[$];
	wire logic o_ready, o_done, o_ce_n, o_oe_n, o_we_n, o_reset_n, o_hv_select, o_word_sel;
	logic i_ready_busy_n = 1'b1;
	wire logic o_dev_ready;
	wire logic [15:0] o_rdata, o_dq_out, o_dq_oe, i_dq_in, fo, fe;
	wire logic [17:0] o_addr;
	int fail_count = 0, checked = 0;
	always #10 i_clk = ~i_clk;
	always @(posedge i_clk) idle <= ~idle;
	assign i_dq_in = o_dq_oe & o_dq_out | ~o_dq_oe & (fe & fo | ~fe & idle);
	fbd_host u_fbd_host (.i_clk(i_clk), .i_reset(i_reset), .i_req(i_req), .i_op(i_op),
		.i_byte_mode(i_byte_mode), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready),
		.o_done(o_done), .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
		.o_reset_n(o_reset_n), .o_hv_select(o_hv_select), .o_word_sel(o_word_sel),
		.o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(i_dq_in),
		.i_ready_busy_n(i_ready_busy_n), .o_dev_ready(o_dev_ready));
	fbd_flash_model u_fbd_flash_model (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
		.i_reset_n(o_reset_n), .i_hv(o_hv_select), .i_word(o_word_sel), .i_addr(o_addr),
		.i_dq(i_dq_in), .o_dq(fo), .o_dq_en(fe));
	task automatic final_report;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic wait_ready;
		for (int n = 0; o_ready !== 1'b1; n++) begin
			if (n == 60) begin
				fail_count++;
				$display("CHECK FAILED o_ready exp 1 seen %b", o_ready);
				final_report();
			end
			@(negedge i_clk);
		end
	endtask : wait_ready
	task automatic check_dev_ready(input logic lvl, input logic exp);
		i_ready_busy_n = lvl;
		repeat (4) @(negedge i_clk);
		checked++;
		if (o_dev_ready !== exp) begin
			fail_count++;
			$display("CHECK FAILED o_dev_ready exp %b seen %b", exp, o_dev_ready);
		end
	endtask : check_dev_ready
	always @(negedge i_clk) if (o_done === 1'b1) begin
		checked++;
		if (q.size() == 0) begin
			fail_count++;
			$display("CHECK FAILED queue exp 1 seen 0");
		end else begin
			e = q.pop_front();
			s = e[16] ? u_fbd_flash_model.cmd_ff : o_rdata;
			if (s !== e[15:0]) begin
				fail_count++;
				$display("CHECK FAILED result exp %h seen %h", e[15:0], s);
			end
		end
	end
	initial begin
		void'($urandom(32'hB609));
		repeat (6) @(negedge i_clk);
		i_reset = 1'b0;
		check_dev_ready(1'b1, 1'b1);
		check_dev_ready(1'b0, 1'b0);
		check_dev_ready(1'b1, 1'b1);
		i_ready_busy_n = 1'b0;
		@(negedge i_clk);
		check_dev_ready(1'b1, 1'b1);
		for (int k = 0; k < 40; k++) begin
			wait_ready();
			{i_byte_mode, i_addr} = 20'($urandom);
			i_wdata = 16'($urandom);
			i_op = fbd_op_t'(k);
			w = (i_byte_mode ? i_addr[16:1] : i_addr[15:0]) ^ 16'h5A3C;
			case (i_op)
				2'h0: q.push_back({1'b0, i_byte_mode ? {8'h0, i_addr[0] ? w[15:8] : w[7:0]} : w});
				2'h1: q.push_back({1'b1, i_byte_mode ? {8'h0, i_wdata[7:0]} : i_wdata});
				default: q.push_back({14'h2000, i_op[0], 2'h2});
			endcase
			i_req = 1'b1;
			@(negedge i_clk);
			i_req = 1'b0;
		end
		wait_ready();
		@(negedge i_clk);
		if (q.size() != 0) begin
			fail_count++;
			$display("CHECK FAILED queue exp 0 seen %0d", q.size());
		end
		final_report();
	end
endmodule : test_flash_bus_operation_decode
`default_nettype wire
